/* File: design/did_decoder.sv */
// did_decoder: assignable digital input function decoder of the servo drive.
// assumes: terminal pins are asynchronous; absolute transfer status and
// general output sources come from logic on sys_clk_in.
//
// Operation
// - in internal mode, trigger picks stored command from six select inputs
// - a state change on an event input starts a preset procedure
// - first-style enable enters absolute mode with its transfer signals
// - first-style mode fixes fourth input, second and third outputs
// - second-style enable enters absolute mode with its transfer signals
// - second-style mode fixes fourth input and, with first-style off, second to fourth outputs
// - origin clear clears the encoder multi-turn count
// - origin clear only acts while an absolute enable is on
// - stop input halts motion in internal mode
// - mode switch off gives pulse mode, on gives internal mode
// - speed or torque mode exchanges shared start and limit functions
// - top mode digit 0 uses user terminals, 1 uses defaults
`timescale 1ns/10ps
module did_decoder #(
   parameter int POS_W = did_pkg::POS_W,
   parameter int EV_N = did_pkg::EV_N
) (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic rstn_in,
   // register port
   input wire logic [7:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [31:0] reg_rdata_out,
   // input terminals
   input wire logic [POS_W-1:0] position_select_in,
   input wire logic position_command_trigger_in,
   input wire logic [EV_N-1:0] event_trigger_input_in,
   input wire logic first_style_absolute_transfer_enable_in,
   input wire logic second_style_absolute_transfer_enable_in,
   input wire logic absolute_origin_clear_in,
   input wire logic stop_in,
   input wire logic position_mode_switch_in,
   input wire logic fourth_digital_input_in,
   input wire logic forward_start_input_in,
   input wire logic reverse_select_input_in,
   // drive-side sources
   input wire logic absolute_transfer_ready_in,
   input wire logic absolute_transfer_data_in,
   input wire logic absolute_transmit_ready_in,
   input wire logic absolute_data_bit_0_in,
   input wire logic absolute_data_bit_1_in,
   input wire logic [7:0] general_output_src_in,
   // decoded functions
   output logic [POS_W-1:0] position_index_out,
   output logic position_load_out,
   output logic [EV_N-1:0] event_start_out,
   output logic internal_command_position_mode_out,
   output logic stop_motion_out,
   output logic absolute_mode_out,
   output logic absolute_transfer_request_out,
   output logic multi_turn_clear_out,
   output logic [2:0] fourth_input_function_out,
   output logic fourth_input_level_out,
   output logic start_function_out,
   output logic limit_function_out,
   // output terminals
   output logic second_digital_output_out,
   output logic third_digital_output_out,
   output logic fourth_digital_output_out
);
   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      logic [15:0] ctrl;
      logic [7:0] evcfg;
      logic [11:0] termsel;
      logic [31:0] rdata;
      logic trig_prev;
      logic clr_prev;
      logic [EV_N-1:0] ev_prev;
      logic [POS_W-1:0] pos_idx;
      logic pos_load;
      logic [EV_N-1:0] ev_start;
      logic int_mode;
      logic stop_motion;
      logic abs_mode;
      logic abs_req;
      logic mt_clear;
      logic [2:0] di4_fn;
      logic di4_lvl;
      logic start_fn;
      logic limit_fn;
      logic do2;
      logic do3;
      logic do4;
   } did_state_t;

   did_state_t st_q;
   did_state_t st_d;

   localparam int PIN_W = POS_W + EV_N + 9;

   logic [PIN_W-1:0] pin_lvl;
   logic [POS_W-1:0] pos_s;
   logic trig_s;
   logic [EV_N-1:0] ev_s;
   logic first_style_absolute_transfer_enable_s;
   logic second_style_absolute_transfer_enable_s;
   logic clr_s;
   logic stop_s;
   logic msw_s;
   logic di4_s;
   logic fwd_s;
   logic rev_s;

   // ************************************************************
   // pin synchronisers
   // ************************************************************
   did_sync #(
      .W(PIN_W)
   ) u_sync (
      .sys_clk_in(sys_clk_in),
      .rstn_in(rstn_in),
      .pin_in({position_select_in, position_command_trigger_in,
               event_trigger_input_in, first_style_absolute_transfer_enable_in,
               second_style_absolute_transfer_enable_in, absolute_origin_clear_in,
               stop_in, position_mode_switch_in, fourth_digital_input_in,
               forward_start_input_in, reverse_select_input_in}),
      .level_out(pin_lvl)
   );

   assign {pos_s, trig_s, ev_s, first_style_absolute_transfer_enable_s, second_style_absolute_transfer_enable_s, clr_s, stop_s, msw_s, di4_s,
           fwd_s, rev_s} = pin_lvl;

   // ************************************************************
   // helpers
   // ************************************************************
   function automatic logic pick_src(input logic [7:0] src, input logic [2:0] sel);
      pick_src = src[sel];
   endfunction : pick_src

   function automatic logic [2:0] term_sel(input logic dflt, input logic [11:0] ts,
                                           input int lsb, input logic [2:0] def);
      term_sel = dflt ? def : ts[lsb +: did_pkg::SEL_W];
   endfunction : term_sel

   // ************************************************************
   // next state
   // ************************************************************
   logic [3:0] mode_dig;
   logic dflt;
   logic swap;
   logic [2:0] sel2;
   logic [2:0] sel3;
   logic [2:0] sel4;
   logic [EV_N-1:0] ev_chg;

   always_comb begin
      st_d = st_q;
      mode_dig = st_q.ctrl[did_pkg::MODE_LSB +: did_pkg::MODE_W];
      dflt = (st_q.ctrl[did_pkg::TERM_DIGIT_LSB +: 4] == did_pkg::TERM_DEFAULT);
      swap = (mode_dig == did_pkg::MODE_SPEED) || (mode_dig == did_pkg::MODE_TORQUE);
      sel2 = term_sel(dflt, st_q.termsel, did_pkg::SEL_DO2_LSB, did_pkg::DEF_DO2);
      sel3 = term_sel(dflt, st_q.termsel, did_pkg::SEL_DO3_LSB, did_pkg::DEF_DO3);
      sel4 = term_sel(dflt, st_q.termsel, did_pkg::SEL_DO4_LSB, did_pkg::DEF_DO4);
      // register writes
      if (reg_wr_in) begin
         if (reg_addr_in == did_pkg::OFS_CTRL) begin
            st_d.ctrl = reg_wdata_in[15:0];
         end else if (reg_addr_in == did_pkg::OFS_EVCFG) begin
            st_d.evcfg = reg_wdata_in[7:0];
         end else if (reg_addr_in == did_pkg::OFS_TERMSEL) begin
            st_d.termsel = reg_wdata_in[11:0];
         end
      end
      // register reads, answered in the next cycle only
      st_d.rdata = '0;
      if (reg_rd_in) begin
         if (reg_addr_in == did_pkg::OFS_CTRL) begin
            st_d.rdata = {16'h0000, st_q.ctrl};
         end else if (reg_addr_in == did_pkg::OFS_EVCFG) begin
            st_d.rdata = {24'h000000, st_q.evcfg};
         end else if (reg_addr_in == did_pkg::OFS_TERMSEL) begin
            st_d.rdata = {20'h00000, st_q.termsel};
         end else if (reg_addr_in == did_pkg::OFS_STATUS) begin
            st_d.rdata = {16'h0000, 6'h00, st_q.pos_idx, st_q.abs_mode,
                          st_q.stop_motion, st_q.int_mode, dflt};
         end
      end
      // edge memory
      st_d.trig_prev = trig_s;
      st_d.clr_prev = clr_s;
      st_d.ev_prev = ev_s;
      st_d.int_mode = msw_s;
      st_d.stop_motion = msw_s && stop_s;
      // position command selection on the trigger rising edge
      st_d.pos_load = 1'b0;
      if (msw_s && trig_s && !st_q.trig_prev) begin
         st_d.pos_idx = pos_s;
         st_d.pos_load = 1'b1;
      end
      // event triggers: enable mask, then any change or rising only
      ev_chg = ev_s ^ st_q.ev_prev;
      for (int i = 0; i < EV_N; i++) begin
         st_d.ev_start[i] = st_q.evcfg[i] && ev_chg[i] &&
                            (st_q.evcfg[did_pkg::EV_ANY_LSB + i] || ev_s[i]);
      end
      // absolute transfer modes
      st_d.abs_mode = first_style_absolute_transfer_enable_s || second_style_absolute_transfer_enable_s;
      st_d.abs_req = (first_style_absolute_transfer_enable_s || second_style_absolute_transfer_enable_s) && di4_s;
      st_d.mt_clear = (first_style_absolute_transfer_enable_s || second_style_absolute_transfer_enable_s) && clr_s && !st_q.clr_prev;
      st_d.di4_fn = term_sel(dflt, st_q.termsel, did_pkg::SEL_DI4_LSB, did_pkg::DEF_DI4);
      // a fixed transfer role takes the fourth input away from its assigned use
      st_d.di4_lvl = !(first_style_absolute_transfer_enable_s || second_style_absolute_transfer_enable_s) && di4_s;
      st_d.start_fn = swap ? rev_s : fwd_s;
      st_d.limit_fn = swap ? fwd_s : rev_s;
      if (first_style_absolute_transfer_enable_s) begin
         st_d.do2 = absolute_transfer_ready_in;
         st_d.do3 = absolute_transfer_data_in;
         st_d.do4 = pick_src(general_output_src_in, sel4);
      end else if (second_style_absolute_transfer_enable_s) begin
         st_d.do2 = absolute_transmit_ready_in;
         st_d.do3 = absolute_data_bit_0_in;
         st_d.do4 = absolute_data_bit_1_in;
      end else begin
         st_d.do2 = pick_src(general_output_src_in, sel2);
         st_d.do3 = pick_src(general_output_src_in, sel3);
         st_d.do4 = pick_src(general_output_src_in, sel4);
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         st_q <= '0;
         st_q.ctrl <= did_pkg::CTRL_RST;
         st_q.evcfg <= did_pkg::EVCFG_RST;
         st_q.termsel <= did_pkg::TERMSEL_RST;
      end else begin
         st_q <= st_d;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign reg_rdata_out = st_q.rdata;
   assign position_index_out = st_q.pos_idx;
   assign position_load_out = st_q.pos_load;
   assign event_start_out = st_q.ev_start;
   assign internal_command_position_mode_out = st_q.int_mode;
   assign stop_motion_out = st_q.stop_motion;
   assign absolute_mode_out = st_q.abs_mode;
   assign absolute_transfer_request_out = st_q.abs_req;
   assign multi_turn_clear_out = st_q.mt_clear;
   assign fourth_input_function_out = st_q.di4_fn;
   assign fourth_input_level_out = st_q.di4_lvl;
   assign start_function_out = st_q.start_fn;
   assign limit_function_out = st_q.limit_fn;
   assign second_digital_output_out = st_q.do2;
   assign third_digital_output_out = st_q.do3;
   assign fourth_digital_output_out = st_q.do4;

   // ************************************************************
   // checks
   // ************************************************************
   property p_pos_load;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      (msw_s && trig_s && !st_q.trig_prev) |=> (position_load_out &&
         position_index_out == $past(pos_s));
   endproperty
   a_pos_load: assert property (p_pos_load)
      else $error("trigger edge did not latch the position index");

   property p_pos_hold;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      !position_load_out |-> $stable(position_index_out);
   endproperty
   a_pos_hold: assert property (p_pos_hold)
      else $error("position index moved without a trigger edge");

   property p_ev;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      (st_q.evcfg[0] && (ev_s[0] != st_q.ev_prev[0]) && st_q.evcfg[EV_N])
      |=> event_start_out[0];
   endproperty
   a_ev: assert property (p_ev)
      else $error("event change not reported");

   property p_abs_enter;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      (first_style_absolute_transfer_enable_s || second_style_absolute_transfer_enable_s) |=> absolute_mode_out;
   endproperty
   a_abs_enter: assert property (p_abs_enter)
      else $error("absolute mode not entered");

   property p_first_fix;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      first_style_absolute_transfer_enable_s |=> (second_digital_output_out == $past(absolute_transfer_ready_in)
         && third_digital_output_out == $past(absolute_transfer_data_in));
   endproperty
   a_first_fix: assert property (p_first_fix)
      else $error("first-style outputs not fixed");

   property p_second_fix;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      (second_style_absolute_transfer_enable_s && !first_style_absolute_transfer_enable_s) |=> (fourth_digital_output_out ==
         $past(absolute_data_bit_1_in));
   endproperty
   a_second_fix: assert property (p_second_fix)
      else $error("second-style data bit 1 not on fourth output");

   property p_clr_gate;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      !(first_style_absolute_transfer_enable_s || second_style_absolute_transfer_enable_s) |=> !multi_turn_clear_out;
   endproperty
   a_clr_gate: assert property (p_clr_gate)
      else $error("origin clear acted outside absolute mode");

   property p_clr_act;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      ((first_style_absolute_transfer_enable_s || second_style_absolute_transfer_enable_s) && clr_s && !st_q.clr_prev) |=> multi_turn_clear_out;
   endproperty
   a_clr_act: assert property (p_clr_act)
      else $error("origin clear edge in absolute mode did not clear the count");

   property p_int_mode;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      msw_s |=> internal_command_position_mode_out;
   endproperty
   a_int_mode: assert property (p_int_mode)
      else $error("mode switch on did not select internal mode");

   property p_stop;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      stop_motion_out |-> $past(msw_s) && $past(stop_s);
   endproperty
   a_stop: assert property (p_stop)
      else $error("stop outside internal mode");

   property p_swap;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      swap ##1 swap |-> start_function_out == $past(rev_s);
   endproperty
   a_swap: assert property (p_swap)
      else $error("start and limit not exchanged");
endmodule : did_decoder

/* File: design/did_pkg.sv */
// did_pkg: shared constants of the digital input function decoder.
// assumes: included by name only, nothing imported.
package did_pkg;
   // ************************************************************
   // register offsets (byte addresses)
   // ************************************************************
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_EVCFG = 8'h04;
   localparam logic [7:0] OFS_TERMSEL = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0C;
   // ************************************************************
   // control mode parameter fields
   // ************************************************************
   localparam int MODE_LSB = 0;
   localparam int MODE_W = 4;
   localparam int TERM_DIGIT_LSB = 12;
   localparam logic [3:0] MODE_SPEED = 4'h2;
   localparam logic [3:0] MODE_TORQUE = 4'h4;
   localparam logic [3:0] TERM_USER = 4'h0;
   localparam logic [3:0] TERM_DEFAULT = 4'h1;
   localparam logic [15:0] CTRL_RST = 16'h0000;
   // ************************************************************
   // event config and terminal select fields
   // ************************************************************
   localparam int EV_N = 4;
   localparam int EV_ANY_LSB = 4;
   localparam logic [7:0] EVCFG_RST = 8'h00;
   localparam int SEL_W = 3;
   localparam int SEL_DO2_LSB = 0;
   localparam int SEL_DO3_LSB = 3;
   localparam int SEL_DO4_LSB = 6;
   localparam int SEL_DI4_LSB = 9;
   localparam logic [11:0] TERMSEL_RST = 12'h000;
   // recommended default sources when the top digit selects defaults
   localparam logic [2:0] DEF_DO2 = 3'h0;
   localparam logic [2:0] DEF_DO3 = 3'h1;
   localparam logic [2:0] DEF_DO4 = 3'h2;
   localparam logic [2:0] DEF_DI4 = 3'h0;
   localparam int POS_W = 6;
endpackage : did_pkg

/* File: design/did_sync.sv */
// did_sync: three-stage pin synchroniser with agreement filter.
// assumes: pins are asynchronous to sys_clk_in; reset is synchronous.
`timescale 1ns/10ps
module did_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic rstn_in,
   // pins and filtered levels
   input wire logic [W-1:0] pin_in,
   output logic [W-1:0] level_out
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] val;
   } did_sync_t;

   did_sync_t st_q;
   did_sync_t st_d;

   always_comb begin
      st_d = st_q;
      st_d.s1 = pin_in;
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      // a bit moves only once stages two and three agree
      for (int i = 0; i < W; i++) begin
         if (st_q.s2[i] == st_q.s3[i]) begin
            st_d.val[i] = st_q.s3[i];
         end
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign level_out = st_q.val;
endmodule : did_sync

/* File: dv/did_host_model.sv */
// did_host_model: host controller that drives the drive's input terminals.
// assumes: sys_clk_in is the drive clock; pins change just after its rising edge.
`timescale 1ns/10ps
module did_host_model (
   // clock
   input wire logic sys_clk_in,
   // level terminals
   output logic [5:0] sel_out,
   output logic [6:0] lvl_out,
   // edge terminals: events, trigger, origin clear
   output logic [5:0] edge_out
);
   initial begin
      sel_out = 6'h00;
      lvl_out = 7'h00;
      edge_out = 6'h00;
   end
   // each change is held 8 cycles: the filter needs it stable for 2
   task automatic hold();
      repeat (8) @(posedge sys_clk_in);
      #1;
   endtask : hold
   // lv: {first, second, stop, mode, fourth, forward, reverse}
   task automatic levels(input logic [5:0] sel, input logic [6:0] lv);
      @(posedge sys_clk_in);
      sel_out <= sel;
      lvl_out <= lv;
      hold();
   endtask : levels
   task automatic pulse(input int which);
      @(posedge sys_clk_in);
      edge_out[which] <= 1'b1;
      hold();
      @(posedge sys_clk_in);
      edge_out[which] <= 1'b0;
      hold();
   endtask : pulse
endmodule : did_host_model

/* File: dv/did_decoder_bench.sv */
// did_decoder_bench: self-checking bench of the digital input decoder.
// assumes: did_host_model drives the terminals; bench drives register port.
`timescale 1ns/10ps
module did_decoder_bench;
   logic sys_clk_in = 1'b0;
   logic rstn_in = 1'b0;
   logic [7:0] reg_addr_in = 8'h00;
   logic [31:0] reg_wdata_in = 32'h0000_0000;
   logic reg_wr_in = 1'b0;
   logic reg_rd_in = 1'b0;
   logic [4:0] abs_src = 5'h00;
   logic [7:0] general_output_src_in = 8'h00;
   logic [31:0] reg_rdata_out;
   logic [5:0] sel, position_index_out;
   logic [6:0] lv;
   logic [5:0] ed;
   logic [3:0] event_start_out;
   logic [2:0] fourth_input_function_out;
   logic position_load_out, internal_command_position_mode_out, stop_motion_out;
   logic absolute_mode_out, absolute_transfer_request_out, multi_turn_clear_out;
   logic fourth_input_level_out, start_function_out, limit_function_out;
   logic second_digital_output_out, third_digital_output_out, fourth_digital_output_out;
   int miscompares = 0;
   int cmp_count = 0;
   int load_n = 0;
   int clr_n = 0;
   int ev_n [4] = '{0, 0, 0, 0};
   always #5 sys_clk_in = ~sys_clk_in;
   did_host_model host (.sys_clk_in, .sel_out(sel), .lvl_out(lv), .edge_out(ed));
   did_decoder DUT (.sys_clk_in, .rstn_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
      .reg_rd_in, .reg_rdata_out, .position_select_in(sel),
      .position_command_trigger_in(ed[4]), .event_trigger_input_in(ed[3:0]),
      .first_style_absolute_transfer_enable_in(lv[6]),
      .second_style_absolute_transfer_enable_in(lv[5]),
      .absolute_origin_clear_in(ed[5]), .stop_in(lv[4]), .position_mode_switch_in(lv[3]),
      .fourth_digital_input_in(lv[2]), .forward_start_input_in(lv[1]),
      .reverse_select_input_in(lv[0]), .absolute_transfer_ready_in(abs_src[4]),
      .absolute_transfer_data_in(abs_src[3]), .absolute_transmit_ready_in(abs_src[2]),
      .absolute_data_bit_0_in(abs_src[1]), .absolute_data_bit_1_in(abs_src[0]),
      .general_output_src_in, .position_index_out, .position_load_out, .event_start_out,
      .internal_command_position_mode_out, .stop_motion_out, .absolute_mode_out,
      .absolute_transfer_request_out, .multi_turn_clear_out, .fourth_input_function_out,
      .fourth_input_level_out, .start_function_out, .limit_function_out,
      .second_digital_output_out, .third_digital_output_out, .fourth_digital_output_out);
   // ************************************************************
   // pulse counters and shared tasks
   // ************************************************************
   always @(posedge sys_clk_in) begin
      if (position_load_out === 1'b1) load_n++;
      if (multi_turn_clear_out === 1'b1) clr_n++;
      for (int i = 0; i < 4; i++) if (event_start_out[i] === 1'b1) ev_n[i]++;
   end
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk_in);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge sys_clk_in);
      reg_wr_in <= 1'b0;
      repeat (3) @(posedge sys_clk_in);
      #1;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge sys_clk_in);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(posedge sys_clk_in);
      reg_rd_in <= 1'b0;
      #1;
      d = reg_rdata_out;
   endtask : rd
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : tally_and_finish
   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic t_regs();
      logic [31:0] d;
      rd(did_pkg::OFS_EVCFG, d);
      chk("evcfg_rst", {24'h0, did_pkg::EVCFG_RST}, d);
      rd(did_pkg::OFS_TERMSEL, d);
      chk("termsel_rst", {20'h0, did_pkg::TERMSEL_RST}, d);
      rd(8'h10, d);
      chk("unmapped", 32'h0000_0000, d);
      wr(did_pkg::OFS_STATUS, 32'hFFFF_FFFF);
      rd(did_pkg::OFS_STATUS, d);
      chk("status_ro", 32'h0000_0000, d);
      wr(did_pkg::OFS_CTRL, 32'hFFFF_FFFF);
      rd(did_pkg::OFS_CTRL, d);
      chk("ctrl_rw", 32'h0000_FFFF, d);
      wr(did_pkg::OFS_CTRL, 32'h0000_0000);
   endtask : t_regs
   task automatic t_trigger();
      int n;
      logic [31:0] d;
      host.levels(6'h32, 7'h00);
      chk("internal_mode", 32'h0, internal_command_position_mode_out);
      n = load_n;
      host.pulse(4);
      chk("load_in_pulse_mode", 32'h0, load_n - n);
      host.levels(6'h32, 7'h08);
      chk("internal_mode", 32'h1, internal_command_position_mode_out);
      n = load_n;
      host.pulse(4);
      chk("load_count", 32'h1, load_n - n);
      chk("index", 32'h32, position_index_out);
      host.levels(6'h0D, 7'h18);
      chk("index_held", 32'h32, position_index_out);
      chk("stop_internal", 32'h1, stop_motion_out);
      rd(did_pkg::OFS_STATUS, d);
      chk("status", 32'h326, d[9:0]);
      host.levels(6'h0D, 7'h10);
      chk("stop_pulse_mode", 32'h0, stop_motion_out);
   endtask : t_trigger
   task automatic t_events();
      logic [7:0] cfg [3] = '{8'h00, 8'h0F, 8'hFF};
      int n;
      host.levels(6'h00, 7'h08);
      for (int c = 0; c < 3; c++) begin
         wr(did_pkg::OFS_EVCFG, {24'h0, cfg[c]});
         for (int i = 0; i < 4; i++) begin
            n = ev_n[i];
            host.pulse(i);
            chk("event_count", c, ev_n[i] - n);
         end
      end
   endtask : t_events
   task automatic t_absolute();
      int n;
      wr(did_pkg::OFS_TERMSEL, 32'h0000_0000);
      @(posedge sys_clk_in);
      abs_src <= 5'b10000;
      general_output_src_in <= 8'hFF;
      host.levels(6'h00, 7'h04);
      chk("request_off", 32'h0, absolute_transfer_request_out);
      chk("di4_level_normal", 32'h1, fourth_input_level_out);
      n = clr_n;
      host.pulse(5);
      chk("clear_ignored", 32'h0, clr_n - n);
      host.levels(6'h00, 7'h44);
      chk("abs_mode_first", 32'h1, absolute_mode_out);
      chk("request_first", 32'h1, absolute_transfer_request_out);
      chk("di4_level", 32'h0, fourth_input_level_out);
      chk("do2_do3_do4_first", 32'h5, {second_digital_output_out, third_digital_output_out,
         fourth_digital_output_out});
      n = clr_n;
      host.pulse(5);
      chk("clear_first", 32'h1, clr_n - n);
      @(posedge sys_clk_in);
      abs_src <= 5'b00110;
      general_output_src_in <= 8'h00;
      host.levels(6'h00, 7'h24);
      chk("abs_mode_second", 32'h1, absolute_mode_out);
      chk("request_second", 32'h1, absolute_transfer_request_out);
      chk("do2_do3_do4_second", 32'h6, {second_digital_output_out, third_digital_output_out,
         fourth_digital_output_out});
      n = clr_n;
      host.pulse(5);
      chk("clear_second", 32'h1, clr_n - n);
      host.levels(6'h00, 7'h00);
      chk("abs_mode_off", 32'h0, absolute_mode_out);
   endtask : t_absolute
   task automatic t_swap_and_terminals();
      logic [3:0] mode [3] = '{4'h0, did_pkg::MODE_SPEED, did_pkg::MODE_TORQUE};
      logic [31:0] d;
      host.levels(6'h00, 7'h02);
      for (int m = 0; m < 3; m++) begin
         wr(did_pkg::OFS_CTRL, {28'h0, mode[m]});
         chk("start_limit", (m == 0) ? 32'h2 : 32'h1, {start_function_out,
            limit_function_out});
      end
      @(posedge sys_clk_in);
      general_output_src_in <= 8'h20;
      wr(did_pkg::OFS_TERMSEL, 32'h0000_0605);
      wr(did_pkg::OFS_CTRL, 32'h0000_0000);
      chk("do2_user", 32'h1, second_digital_output_out);
      chk("di4_user", 32'h3, fourth_input_function_out);
      wr(did_pkg::OFS_CTRL, 32'h0000_1000);
      chk("do2_default", general_output_src_in[did_pkg::DEF_DO2],
         second_digital_output_out);
      chk("di4_default", did_pkg::DEF_DI4, fourth_input_function_out);
      rd(did_pkg::OFS_STATUS, d);
      chk("status_default", 32'h1, d[0]);
   endtask : t_swap_and_terminals
   // ************************************************************
   // main sequence and watchdog
   // ************************************************************
   initial begin
      repeat (10) @(posedge sys_clk_in);
      rstn_in <= 1'b1;
      t_regs();
      t_trigger();
      t_events();
      t_absolute();
      t_swap_and_terminals();
      tally_and_finish();
   end
   initial begin
      repeat (20000) @(posedge sys_clk_in);
      miscompares++;
      $display("[ERR] watchdog expected end seen hang");
      tally_and_finish();
   end
endmodule : did_decoder_bench
